// ### motor_channel_pkg.sv
// Purpose: shared constants and types for the motor channel manager
// Assumes: six motor outputs, one peripheral clock
// Notes:   routing table rows are indexed by {interval, cfg bit}
//
// Function
// - preload next phase bits, copy all six into phase register on C event
// - phase clear drives inverse polarity; phase set drives polarity, PWM allowed
// - direct access mode writes next phase bits straight into phase register
// - direct access mode: any next phase write generates a C event
// - direct access mode: PWM routing chosen only by Z-to-C config bit
// - direct access mode: timer clock off, D and Z events ignored
// - group bit 0 puts output in high group, 1 in low group
// - multiplexer applies PWM to high, low or both groups per step state
// - demag config bit preloaded, taken on C event, governs C-to-D at once
// - dedicated config bit governs routing between D and Z events
// - dedicated config bit governs routing from Z until next C
// - emergency input low forces outputs to reset state asynchronously
// - emergency input clears the motor output enable bit
// - emergency raises interrupt request only while its mask bit is set
// - emergency shutdown works with the clock stopped
// - output reset state selectable: high impedance, low or high
package motor_channel_pkg;

    // ------------------------------------------------------------
    // widths and layout
    // ------------------------------------------------------------
    localparam int unsigned NUM_CH = 6;
    localparam int unsigned ROUTE_W = 2;
    localparam int unsigned ROUTE_ROWS = 6;
    // bit positions inside one routing entry
    localparam int unsigned ROUTE_HIGH_BIT = 0;
    localparam int unsigned ROUTE_LOW_BIT = 1;
    localparam logic [NUM_CH-1:0] PHASE_RST = 6'h00;
    localparam logic [NUM_CH-1:0] ALL_CH = 6'h3f;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [NUM_CH-1:0] ch_t;
    typedef logic [ROUTE_W*ROUTE_ROWS-1:0] route_tbl_t;

    typedef enum logic [1:0] {
        OUT_RST_HIZ,
        OUT_RST_LOW,
        OUT_RST_HIGH
    } out_rst_e;

    typedef enum logic [1:0] {
        STEP_DEMAG,
        STEP_D_TO_Z,
        STEP_Z_TO_C
    } step_e;

    typedef struct packed {
        logic direct_access;
        logic clock_enable;
        logic pwm_cfg_demag;
        logic pwm_cfg_d_to_z;
        logic pwm_cfg_z_to_c;
    } motor_cfg_s;

    typedef struct packed {
        logic c_evt;
        logic d_evt;
        logic z_evt;
    } step_evt_s;

    // default routing: cfg 0 -> high group, cfg 1 -> low group,
    // row order {STEP_DEMAG,0},{DEMAG,1},{D_TO_Z,0}...{Z_TO_C,1}
    localparam route_tbl_t ROUTE_DEFAULT = 12'h999;

endpackage : motor_channel_pkg

// ### motor_channel_manager.sv
// Purpose: phase state, PWM routing and emergency stop of six outputs
// Assumes: all inputs synchronous to clk except rst and emergency_stop_n
// Notes:   emergency path acts without clk through the flop resets
`timescale 1ns/1ns
`default_nettype none

module motor_channel_manager
    import motor_channel_pkg::*;
#(
    parameter out_rst_e   OUT_RST   = OUT_RST_HIZ,
    parameter route_tbl_t ROUTE_TBL = ROUTE_DEFAULT
) (
    // ------------------------------------------------------------
    // clock and reset
    // ------------------------------------------------------------
    input  wire logic       clk,
    input  wire logic       rst,
    // ------------------------------------------------------------
    // software control
    // ------------------------------------------------------------
    input  wire logic       next_phase_wr,
    input  wire ch_t        next_phase_bits,
    input  wire ch_t        polarity_bits,
    input  wire ch_t        group_assign_reg,
    input  wire motor_cfg_s cfg,
    input  wire logic       moe_set,
    input  wire logic       emergency_irq_mask,
    input  wire logic       emergency_irq_clr,
    // ------------------------------------------------------------
    // event detection and pwm source
    // ------------------------------------------------------------
    input  wire step_evt_s  evt,
    input  wire logic       pwm_in,
    // ------------------------------------------------------------
    // emergency pin
    // ------------------------------------------------------------
    input  wire logic       emergency_stop_n,
    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    output var  ch_t        phase_state_reg,
    output var  ch_t        next_phase_pre,
    output var  logic       motor_output_enable,
    output var  logic       emergency_irq,
    output var  logic       timer_clk_en,
    output var  logic       commutation_evt,
    output var  logic       d_evt_seen,
    output var  logic       z_evt_seen,
    output var  step_e      step_state,
    // ------------------------------------------------------------
    // motor outputs to gate drivers
    // ------------------------------------------------------------
    output var  ch_t        motor_outputs,
    output var  ch_t        motor_outputs_oe
);

    // ------------------------------------------------------------
    // reset constants
    // ------------------------------------------------------------
    // constant per option, so it may feed an async reset
    localparam ch_t OUT_RST_LVL =
        (OUT_RST == OUT_RST_HIGH) ? ALL_CH : PHASE_RST;
    localparam ch_t OUT_RST_OE =
        (OUT_RST == OUT_RST_HIZ) ? PHASE_RST : ALL_CH;

    // emergency is a reset, so no clock is needed to kill outputs
    logic kill;
    assign kill = rst | ~emergency_stop_n;

    // ------------------------------------------------------------
    // phase state and preload
    // ------------------------------------------------------------
    ch_t   phase_r;
    ch_t   phase_nxt;
    ch_t   pre_r;
    ch_t   pre_nxt;
    logic  demag_r;
    logic  demag_nxt;
    logic  comm;

    // direct write creates its own commutation
    assign comm = evt.c_evt
                | (cfg.direct_access & next_phase_wr);

    always_comb begin
        pre_nxt   = pre_r;
        phase_nxt = phase_r;
        demag_nxt = demag_r;
        if (next_phase_wr) begin
            pre_nxt = next_phase_bits;
        end
        if (cfg.direct_access && next_phase_wr) begin
            phase_nxt = next_phase_bits;
        end else if (comm) begin
            phase_nxt = pre_r;
        end
        if (comm) begin
            demag_nxt = cfg.pwm_cfg_demag;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_r <= PHASE_RST;
            pre_r   <= PHASE_RST;
            demag_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            pre_r   <= pre_nxt;
            demag_r <= demag_nxt;
        end
    end

    // ------------------------------------------------------------
    // step interval tracking
    // ------------------------------------------------------------
    step_e step_r;
    step_e step_nxt;
    logic  d_ok;
    logic  z_ok;

    assign d_ok = evt.d_evt & ~cfg.direct_access;
    assign z_ok = evt.z_evt & ~cfg.direct_access;

    always_comb begin
        step_nxt = step_r;
        // a C event wins over a D or Z in the same cycle
        if (comm) begin
            step_nxt = STEP_DEMAG;
        end else begin
            case (step_r)
                STEP_DEMAG: begin
                    if (d_ok) begin
                        step_nxt = STEP_D_TO_Z;
                    end
                end
                STEP_D_TO_Z: begin
                    if (z_ok) begin
                        step_nxt = STEP_Z_TO_C;
                    end
                end
                STEP_Z_TO_C: begin
                    step_nxt = STEP_Z_TO_C;
                end
                default: begin
                    step_nxt = STEP_DEMAG;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            step_r <= STEP_DEMAG;
        end else begin
            step_r <= step_nxt;
        end
    end

    // ------------------------------------------------------------
    // pwm routing lookup
    // ------------------------------------------------------------
    logic                       cfg_bit;
    logic [2:0]                 row;
    logic [ROUTE_W-1:0]         route;

    always_comb begin
        cfg_bit = cfg.pwm_cfg_z_to_c;
        row     = {STEP_Z_TO_C, 1'b0};
        if (cfg.direct_access) begin
            cfg_bit = cfg.pwm_cfg_z_to_c;
            row     = {STEP_Z_TO_C, cfg_bit};
        end else begin
            case (step_r)
                STEP_DEMAG:  cfg_bit = demag_r;
                STEP_D_TO_Z: cfg_bit = cfg.pwm_cfg_d_to_z;
                STEP_Z_TO_C: cfg_bit = cfg.pwm_cfg_z_to_c;
                default:     cfg_bit = cfg.pwm_cfg_z_to_c;
            endcase
            row = {step_r, cfg_bit};
        end
        route = ROUTE_TBL[row*ROUTE_W +: ROUTE_W];
    end

    // ------------------------------------------------------------
    // per channel output logic
    // ------------------------------------------------------------
    ch_t out_nxt;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic gated;
        logic on;
        // group bit picks which bit of the routing entry applies
        assign gated = group_assign_reg[i]
                     ? route[ROUTE_LOW_BIT]
                     : route[ROUTE_HIGH_BIT];
        assign on = phase_r[i] & (~gated | pwm_in);
        assign out_nxt[i] = on ? polarity_bits[i]
                               : ~polarity_bits[i];
    end

    // ------------------------------------------------------------
    // motor output enable
    // ------------------------------------------------------------
    logic moe_r;
    logic moe_nxt;

    always_comb begin
        moe_nxt = moe_r;
        if (moe_set) begin
            moe_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge kill) begin
        if (kill) begin
            moe_r <= 1'b0;
        end else begin
            moe_r <= moe_nxt;
        end
    end

    // ------------------------------------------------------------
    // output buffers
    // ------------------------------------------------------------
    ch_t drv_nxt;
    ch_t oe_nxt;

    always_comb begin
        drv_nxt = OUT_RST_LVL;
        oe_nxt  = OUT_RST_OE;
        // disabled outputs sit in the chosen reset state
        if (moe_r) begin
            drv_nxt = out_nxt;
            oe_nxt  = ALL_CH;
        end
    end

    always_ff @(posedge clk or posedge kill) begin
        if (kill) begin
            motor_outputs    <= OUT_RST_LVL;
            motor_outputs_oe <= OUT_RST_OE;
        end else begin
            motor_outputs    <= drv_nxt;
            motor_outputs_oe <= oe_nxt;
        end
    end

    // ------------------------------------------------------------
    // emergency interrupt
    // ------------------------------------------------------------
    logic irq_r;
    logic irq_nxt;

    always_comb begin
        irq_nxt = irq_r;
        if (emergency_irq_clr) begin
            irq_nxt = 1'b0;
        end
        // set wins over clear so a stop is never missed
        if (~emergency_stop_n & emergency_irq_mask) begin
            irq_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // registered status
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_state_reg <= PHASE_RST;
            next_phase_pre  <= PHASE_RST;
            timer_clk_en    <= 1'b0;
            commutation_evt <= 1'b0;
            d_evt_seen      <= 1'b0;
            z_evt_seen      <= 1'b0;
            step_state      <= STEP_DEMAG;
        end else begin
            phase_state_reg <= phase_nxt;
            next_phase_pre  <= pre_nxt;
            timer_clk_en    <= cfg.clock_enable
                             & ~cfg.direct_access;
            commutation_evt <= comm;
            d_evt_seen      <= d_ok & (step_r == STEP_DEMAG);
            z_evt_seen      <= z_ok & (step_r == STEP_D_TO_Z);
            step_state      <= step_nxt;
        end
    end

    assign motor_output_enable = moe_r;
    assign emergency_irq       = irq_r;

endmodule : motor_channel_manager

`default_nettype wire

// ### mcm_monitor.sv
// Purpose: port assertions for the motor channel manager
// Assumes: one clock domain, asynchronous reset rst
// Notes:   outputs lag the phase register by one edge
`timescale 1ns/1ns
`default_nettype none
module mcm_monitor
    import motor_channel_pkg::*;
#(
    parameter out_rst_e OUT_RST = OUT_RST_HIZ
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // stimulus side
    input wire logic       next_phase_wr,
    input wire ch_t        next_phase_bits,
    input wire ch_t        polarity_bits,
    input wire motor_cfg_s cfg,
    input wire step_evt_s  evt,
    input wire logic       pwm_in,
    input wire logic       emergency_stop_n,
    input wire logic       emergency_irq_mask,
    // design side
    input wire ch_t        phase_state_reg,
    input wire ch_t        next_phase_pre,
    input wire logic       motor_output_enable,
    input wire logic       emergency_irq,
    input wire logic       timer_clk_en,
    input wire logic       commutation_evt,
    input wire logic       d_evt_seen,
    input wire logic       z_evt_seen,
    input wire step_e      step_state,
    input wire ch_t        motor_outputs,
    input wire ch_t        motor_outputs_oe
);
    localparam ch_t RST_OE = (OUT_RST == OUT_RST_HIZ) ? 6'h00 : 6'h3f;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----
    // sequences
    // ----
    sequence direct_wr_s;
        cfg.direct_access && next_phase_wr;
    endsequence
    // stop path must not be mistaken for routing
    sequence live_s;
        $past(motor_output_enable) && emergency_stop_n;
    endsequence
    // ----
    // assertions
    // ----
    preload_copy_a: assert property (
        evt.c_evt && !cfg.direct_access
        |=> phase_state_reg == $past(next_phase_pre))
        else $error("phase not loaded from preload");
    direct_write_a: assert property (
        direct_wr_s |=> commutation_evt
        && phase_state_reg == $past(next_phase_bits))
        else $error("direct write not applied");
    comm_pulse_a: assert property (
        evt.c_evt |=> commutation_evt)
        else $error("no commutation after c event");
    timer_off_a: assert property (
        cfg.direct_access |=> !timer_clk_en && !d_evt_seen && !z_evt_seen)
        else $error("timer or events live in direct mode");
    stop_state_a: assert property (
        !emergency_stop_n |-> !motor_output_enable
        && motor_outputs_oe == RST_OE)
        else $error("outputs not in reset state on stop");
    irq_set_a: assert property (
        !emergency_stop_n && emergency_irq_mask |=> emergency_irq)
        else $error("emergency irq missing");
    phase_off_a: assert property (
        live_s |-> ((motor_outputs ^ ~$past(polarity_bits))
        & ~$past(phase_state_reg)) == 6'h00)
        else $error("off channel level wrong");
    pwm_on_a: assert property (
        live_s ##0 $past(pwm_in) |-> ((motor_outputs ^ $past(polarity_bits))
        & $past(phase_state_reg)) == 6'h00)
        else $error("on channel level wrong");
    d_seen_a: assert property (
        evt.d_evt && !cfg.direct_access && step_state == STEP_DEMAG
        |=> d_evt_seen)
        else $error("accepted d event not reported");
    z_seen_a: assert property (
        evt.z_evt && !cfg.direct_access && step_state == STEP_D_TO_Z
        |=> z_evt_seen)
        else $error("accepted z event not reported");
endmodule : mcm_monitor
bind motor_channel_manager mcm_monitor #(.OUT_RST(OUT_RST)) u_mon (
    .clk, .rst, .next_phase_wr, .next_phase_bits, .polarity_bits, .cfg,
    .evt, .pwm_in, .emergency_stop_n, .emergency_irq_mask,
    .phase_state_reg, .next_phase_pre, .motor_output_enable,
    .emergency_irq, .timer_clk_en, .commutation_evt, .d_evt_seen,
    .z_evt_seen, .step_state, .motor_outputs, .motor_outputs_oe
);
`default_nettype wire

// ### gate_drv_model.sv
// Purpose: behavioural model of the six gate drivers
// Assumes: a switch conducts when its line sits at its polarity
// Notes:   an undriven line leaves its switch off
`timescale 1ns/1ns
`default_nettype none
module gate_drv_model
    import motor_channel_pkg::*;
(
    // lines from the channel manager
    input  wire ch_t motor_outputs,
    input  wire ch_t motor_outputs_oe,
    input  wire ch_t polarity_bits,
    // switch states
    output var  ch_t sw_on
);
    always_comb begin
        sw_on = motor_outputs_oe & ~(motor_outputs ^ polarity_bits);
    end
endmodule : gate_drv_model
`default_nettype wire

// ### testbench.sv
// Purpose: self-checking bench for the motor channel manager
// Assumes: default routing table, high impedance reset state
// Notes:   inputs change at the falling edge, except one emergency stop 2ns after it
`timescale 1ns/1ns
`default_nettype none
module testbench
    import motor_channel_pkg::*;;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic next_phase_wr = 1'h0;
    ch_t next_phase_bits = 6'h00;
    ch_t polarity_bits = 6'h00;
    ch_t group_assign_reg = 6'h07;
    motor_cfg_s cfg = '0;
    logic moe_set = 1'h0;
    logic emergency_irq_mask = 1'h0;
    logic emergency_irq_clr = 1'h0;
    step_evt_s evt = '0;
    logic pwm_in = 1'h0;
    logic emergency_stop_n = 1'h1;
    ch_t phase_state_reg, next_phase_pre, motor_outputs, motor_outputs_oe;
    ch_t sw_on;
    logic motor_output_enable, emergency_irq, timer_clk_en;
    logic commutation_evt, d_evt_seen, z_evt_seen;
    step_e step_state;
    int mismatches = 0;
    int n_tests = 0;
    typedef struct packed {
        ch_t ph; ch_t pol; ch_t grp;
        logic [2:0] os; logic [1:0] st; logic pwm; ch_t exp;
    } row_s;
    // os is {demag, d_to_z, z_to_c}; st counts events after c
    row_s rows [6] = '{
        '{6'h3f, 6'h3f, 6'h07, 3'h0, 2'h0, 1'h0, 6'h07},
        '{6'h3f, 6'h3f, 6'h07, 3'h4, 2'h0, 1'h0, 6'h38},
        '{6'h3f, 6'h00, 6'h07, 3'h2, 2'h1, 1'h0, 6'h07},
        '{6'h3f, 6'h00, 6'h07, 3'h6, 2'h2, 1'h0, 6'h38},
        '{6'h05, 6'h0f, 6'h00, 3'h0, 2'h0, 1'h1, 6'h35},
        '{6'h00, 6'h2a, 6'h00, 3'h0, 2'h0, 1'h1, 6'h15}};
    motor_channel_manager dut (
        .clk, .rst, .next_phase_wr, .next_phase_bits, .polarity_bits,
        .group_assign_reg, .cfg, .moe_set, .emergency_irq_mask,
        .emergency_irq_clr, .evt, .pwm_in, .emergency_stop_n,
        .phase_state_reg, .next_phase_pre, .motor_output_enable,
        .emergency_irq, .timer_clk_en, .commutation_evt, .d_evt_seen,
        .z_evt_seen, .step_state, .motor_outputs, .motor_outputs_oe);
    gate_drv_model drv (.motor_outputs, .motor_outputs_oe,
        .polarity_bits, .sw_on);
    // second instance covers the driven-high reset option
    ch_t hi_out, hi_oe;
    motor_channel_manager #(.OUT_RST(OUT_RST_HIGH)) dut_hi (
        .clk, .rst, .next_phase_wr, .next_phase_bits, .polarity_bits,
        .group_assign_reg, .cfg, .moe_set, .emergency_irq_mask,
        .emergency_irq_clr, .evt, .pwm_in, .emergency_stop_n,
        .phase_state_reg(), .next_phase_pre(), .motor_output_enable(),
        .emergency_irq(), .timer_clk_en(), .commutation_evt(),
        .d_evt_seen(), .z_evt_seen(), .step_state(),
        .motor_outputs(hi_out), .motor_outputs_oe(hi_oe));
    // ----
    // tasks
    // ----
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic chk(input ch_t got, input ch_t exp, input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr_phase(input ch_t b);
        next_phase_wr = 1'h1;
        next_phase_bits = b;
        tick(1);
        next_phase_wr = 1'h0;
        tick(1);
    endtask : wr_phase
    task automatic pulse(input step_evt_s e);
        evt = e;
        tick(1);
        evt = '0;
        tick(1);
    endtask : pulse
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    // ----
    // clock, watchdog and tests
    // ----
    initial forever #5 clk = ~clk;
    // whole run is under sixty cycles, far below the 2000-cycle limit
    initial begin
        #20000;
        mismatches++;
        results();
    end
    initial begin
        tick(4);
        rst = 1'h0;
        chk(motor_outputs_oe, 6'h00, "reset oe");
        chk(ch_t'(motor_output_enable), 6'h00, "reset moe");
        chk(hi_oe, 6'h3f, "reset oe high");
        chk(hi_out, 6'h3f, "reset level high");
        moe_set = 1'h1;
        cfg = 5'h08;
        tick(1);
        moe_set = 1'h0;
        tick(1);
        chk(ch_t'(timer_clk_en), 6'h01, "timer on");
        $display("test reset done");
        foreach (rows[i]) begin
            polarity_bits = rows[i].pol;
            group_assign_reg = rows[i].grp;
            cfg = {2'h1, rows[i].os};
            pwm_in = rows[i].pwm;
            wr_phase(rows[i].ph);
            pulse(3'h4);
            if (rows[i].st > 0) pulse(3'h2);
            if (rows[i].st > 1) pulse(3'h1);
            chk(phase_state_reg, rows[i].ph, "phase");
            chk(ch_t'(step_state), ch_t'(rows[i].st), "step");
            chk(motor_outputs, rows[i].exp, "route");
        end
        $display("test routing done");
        polarity_bits = 6'h3f;
        group_assign_reg = 6'h07;
        pwm_in = 1'h0;
        cfg = 5'h0c;
        wr_phase(6'h3f);
        pulse(3'h4);
        cfg = 5'h08;
        tick(2);
        chk(motor_outputs, 6'h38, "demag held");
        wr_phase(6'h2a);
        chk(phase_state_reg, 6'h3f, "no early copy");
        next_phase_wr = 1'h1;
        next_phase_bits = 6'h15;
        evt = 3'h4;
        tick(1);
        next_phase_wr = 1'h0;
        evt = '0;
        chk(phase_state_reg, 6'h2a, "old preload");
        chk(next_phase_pre, 6'h15, "new preload");
        $display("test preload done");
        cfg = 5'h1b;
        tick(2);
        chk(ch_t'(timer_clk_en), 6'h00, "timer off");
        pulse(3'h2);
        chk(ch_t'(step_state), 6'h00, "d ignored");
        next_phase_wr = 1'h1;
        next_phase_bits = 6'h3f;
        tick(1);
        next_phase_wr = 1'h0;
        chk(ch_t'(commutation_evt), 6'h01, "direct c");
        chk(phase_state_reg, 6'h3f, "direct phase");
        tick(2);
        chk(motor_outputs, 6'h38, "direct route");
        $display("test direct done");
        cfg = 5'h08;
        emergency_irq_mask = 1'h1;
        chk(motor_outputs_oe, 6'h3f, "driving");
        #2 emergency_stop_n = 1'h0;
        #1 chk(motor_outputs_oe, 6'h00, "stop oe");
        chk(sw_on, 6'h00, "switches off");
        chk(hi_oe, 6'h3f, "stop oe high");
        chk(hi_out, 6'h3f, "stop level high");
        chk(ch_t'(motor_output_enable), 6'h00, "stop moe");
        tick(1);
        chk(ch_t'(emergency_irq), 6'h01, "irq set");
        emergency_stop_n = 1'h1;
        emergency_irq_clr = 1'h1;
        tick(1);
        emergency_irq_clr = 1'h0;
        emergency_irq_mask = 1'h0;
        emergency_stop_n = 1'h0;
        tick(2);
        chk(ch_t'(emergency_irq), 6'h00, "irq masked");
        emergency_stop_n = 1'h1;
        $display("test emergency done");
        results();
    end
endmodule : testbench
`default_nettype wire
